// [core/rdk_consts.svh]
`ifndef RDK_CONSTS_SVH
`define RDK_CONSTS_SVH

// register byte offsets
`define RDK_A_RELAY   8'h00
`define RDK_A_ALARM   8'h04
`define RDK_A_ALM_LO  8'h08
`define RDK_A_ALM_HI  8'h0C
`define RDK_A_AOUT    8'h10
`define RDK_A_UD_LO   8'h14
`define RDK_A_UD_HI   8'h18
`define RDK_A_MAN     8'h1C
`define RDK_A_FS      8'h20
`define RDK_A_CODE    8'h24
`define RDK_A_STAT    8'h28
`define RDK_A_VOUT    8'h2C
`define RDK_A_CTRL    8'h30

// output modes, alarm sources
`define RDK_M_OFF     3'h0
`define RDK_M_DEF     3'h1
`define RDK_M_USER    3'h2
`define RDK_M_MAN     3'h3
`define RDK_M_CTL     3'h4
`define RDK_SRC_LO    2'h0
`define RDK_SRC_HI    2'h1
`define RDK_SRC_BOTH  2'h2

// reset values; field unit is 0.1 G, voltage unit is 1 mV, percent unit is 0.001 %
`define RDK_RST_RELAY 8'h00
`define RDK_RST_ALARM 2'h0
`define RDK_RST_ALO   32'h00001388
`define RDK_RST_AHI   32'h000088B8
`define RDK_RST_AOUT  8'hA8
`define RDK_RST_UDLO  32'hFFFF7748
`define RDK_RST_UDHI  32'h000088B8
`define RDK_RST_MAN   32'h00000000
`define RDK_RST_FS    32'h000088B8
`define RDK_RST_CODE  12'h123

// limits and scale figures
`define RDK_FIELD_MAX 32'sh003567E0
`define RDK_MAN_MAX   32'sh000186A0
`define RDK_DEF_MV    16'sh0DAC
`define RDK_FULL_MV   16'sh2710
`define RDK_SPAN_MV   16'sh4E20
`define RDK_MV_PER_V  16'sh03E8
`define RDK_PCT_PER_MV 32'sh0000000A
`define RDK_LIM_MIN   4'h1
`define RDK_LIM_MAX   4'hA

// timing
`define RDK_CLK_HZ    40000000
`define RDK_UPD_HZ    30
`define RDK_HOLD_S    5
`define RDK_UPD_CYC   (`RDK_CLK_HZ / `RDK_UPD_HZ)
`define RDK_HOLD_CYC  (`RDK_HOLD_S * `RDK_CLK_HZ)

`endif

// [core/rdk_pkg.sv]
package rdk_pkg;
  typedef struct packed {
    logic       alarm_mode;
    logic       man_on;
    logic [1:0] src;
  } rdk_relay_s;

  typedef struct packed {
    logic [3:0] limit;
    logic       bipolar;
    logic [2:0] mode;
  } rdk_aout_s;

  typedef struct packed {
    rdk_relay_s [1:0]   relay;
    logic               alarm_en;
    logic               alarm_inside;
    logic signed [31:0] alm_lo;
    logic signed [31:0] alm_hi;
    rdk_aout_s          aout;
    logic signed [31:0] ud_lo;
    logic signed [31:0] ud_hi;
    logic signed [31:0] man;
    logic signed [31:0] fs;
    logic [11:0]        code;
  } rdk_cfg_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } rdk_panel_wr_s;

  typedef enum logic [1:0] {
    KP_IDLE,
    KP_CODE,
    KP_REV,
    KP_OFFER
  } rdk_kp_e;
endpackage

// [core/rdk_hold_timer.sv]
`timescale 1ns/1ps
module rdk_hold_timer #(
  parameter int unsigned HOLD_CYC = 200000000
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic key,
  output logic      fire
);
  localparam int W = $clog2(HOLD_CYC + 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         fire_d;

  // counter parks at the end so one long press fires once only
  always_comb begin
    cnt_d  = cnt_q;
    fire_d = 1'b0;
    if (!key) begin
      cnt_d = '0;
    end else if (cnt_q != W'(HOLD_CYC)) begin
      cnt_d  = cnt_q + W'(1);
      fire_d = (cnt_q == W'(HOLD_CYC - 1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
      fire  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fire  <= fire_d;
    end
  end
endmodule // rdk_hold_timer

// [core/rdk_aout_calc.sv]
`timescale 1ns/1ps
`include "rdk_consts.svh"
module rdk_aout_calc (
  input  rdk_pkg::rdk_aout_s    cfg,
  input  wire logic signed [31:0] rdg,
  input  wire logic signed [31:0] fs,
  input  wire logic signed [31:0] ud_lo,
  input  wire logic signed [31:0] ud_hi,
  input  wire logic signed [31:0] man,
  input  wire logic signed [15:0] ctl_mv,
  output logic signed [15:0]      v_mv
);
  import rdk_pkg::*;

  logic signed [63:0] v;
  logic signed [63:0] den;
  logic signed [63:0] lim;

  always_comb begin
    den = 64'(ud_hi) - 64'(ud_lo);
    lim = 64'($signed({12'h000, cfg.limit}) * `RDK_MV_PER_V);
    case (cfg.mode)
      `RDK_M_DEF: begin
        v = (fs != 32'sh0) ? (64'(rdg) * 64'(`RDK_DEF_MV)) / 64'(fs) : 64'sh0;
      end
      `RDK_M_USER: begin
        v = (den != 64'sh0) ?
            ((64'(rdg) - 64'(ud_lo)) * 64'(`RDK_SPAN_MV)) / den - 64'(`RDK_FULL_MV) : 64'sh0;
      end
      `RDK_M_MAN:  v = 64'(man) / 64'(`RDK_PCT_PER_MV);
      `RDK_M_CTL:  v = 64'(ctl_mv);
      default:     v = 64'sh0;
    endcase
    if (v > lim) v = lim;
    if (v < -lim) v = -lim;
    if (!cfg.bipolar && v < 64'sh0) v = 64'sh0;
    v_mv = 16'(v);
  end
endmodule // rdk_aout_calc

// [core/rdk_ctrl.sv]
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "rdk_consts.svh"
module rdk_ctrl #(
  parameter int unsigned UPD_CYC  = `RDK_UPD_CYC,
  parameter int unsigned HOLD_CYC = `RDK_HOLD_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [31:0] field_rdg,
  input  wire logic signed [15:0] ctl_mv,
  input  wire logic               key_enter,
  input  wire logic               key_escape,
  input  wire logic               digit_vld,
  input  wire logic [3:0]         digit,
  input  wire logic               panel_yes,
  input  rdk_pkg::rdk_panel_wr_s  panel_wr,
  output logic [1:0]              relay_out,
  output logic signed [15:0]      aout_mv,
  output logic                    locked,
  output logic                    locked_ind,
  output logic                    code_prompt,
  output logic                    fw_rev_show,
  output logic                    restore_prompt
);
  import rdk_pkg::*;

  localparam int UW = $clog2(UPD_CYC);
  localparam rdk_cfg_s CFG_RST = {`RDK_RST_RELAY, `RDK_RST_ALARM, `RDK_RST_ALO, `RDK_RST_AHI,
                                  `RDK_RST_AOUT, `RDK_RST_UDLO, `RDK_RST_UDHI, `RDK_RST_MAN,
                                  `RDK_RST_FS, `RDK_RST_CODE};

  rdk_cfg_s           cfg_q, cfg_d;
  logic               restore_apb;
  logic               restore_kp;
  logic               w_en;
  logic [7:0]         w_addr;
  logic [31:0]        w_data;
  logic               apb_wr;
  logic               ok_q, ok_d;
  logic [31:0]        prdata_d;
  logic               pready_d;
  logic               pslverr_d;
  logic [UW-1:0]      upd_cnt_q, upd_cnt_d;
  logic               tick_q, tick_d;
  logic signed [15:0] calc_mv;
  logic signed [15:0] aout_d;
  logic signed [15:0] lim_mv;
  logic               alo_q, alo_d;
  logic               ahi_q, ahi_d;
  logic [1:0]         relay_d;
  rdk_kp_e            kp_q, kp_d;
  logic               lock_d;
  logic [7:0]         code_in_q, code_in_d;
  logic [1:0]         dcnt_q, dcnt_d;
  logic               enter_q, esc_q;
  logic               ind_d;
  logic               enter_fire;
  logic               esc_fire;
  logic               enter_rise;
  logic               esc_rise;

  function automatic logic in_field(input logic signed [31:0] s);
    in_field = (s <= `RDK_FIELD_MAX) && (s >= -`RDK_FIELD_MAX);
  endfunction

  // a rejected value leaves the register untouched; a rejected host write also answers with pslverr
  function automatic logic wr_ok(input logic [7:0] a, input logic [31:0] d,
                                 input logic host, input logic bip);
    logic signed [31:0] s;
    s = d;
    case (a)
      `RDK_A_RELAY:  wr_ok = (d[1:0] != 2'h3) && (d[5:4] != 2'h3);
      `RDK_A_ALARM:  wr_ok = 1'b1;
      `RDK_A_CTRL:   wr_ok = host;
      `RDK_A_ALM_LO, `RDK_A_ALM_HI, `RDK_A_UD_LO, `RDK_A_UD_HI: wr_ok = in_field(s);
      `RDK_A_AOUT:   wr_ok = (d[2:0] <= `RDK_M_CTL) && (d[7:4] >= `RDK_LIM_MIN) &&
                             (d[7:4] <= `RDK_LIM_MAX);
      `RDK_A_MAN:    wr_ok = (s <= `RDK_MAN_MAX) &&
                             (s >= (bip ? -`RDK_MAN_MAX : 32'sh0));
      `RDK_A_FS:     wr_ok = (s > 32'sh0);
      `RDK_A_CODE:   wr_ok = host;
      default:       wr_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_val(input logic [7:0] a);
    case (a)
      `RDK_A_RELAY:  rd_val = {24'h000000, cfg_q.relay};
      `RDK_A_ALARM:  rd_val = {30'h00000000, cfg_q.alarm_inside, cfg_q.alarm_en};
      `RDK_A_ALM_LO: rd_val = cfg_q.alm_lo;
      `RDK_A_ALM_HI: rd_val = cfg_q.alm_hi;
      `RDK_A_AOUT:   rd_val = {24'h000000, cfg_q.aout};
      `RDK_A_UD_LO:  rd_val = cfg_q.ud_lo;
      `RDK_A_UD_HI:  rd_val = cfg_q.ud_hi;
      `RDK_A_MAN:    rd_val = cfg_q.man;
      `RDK_A_FS:     rd_val = cfg_q.fs;
      `RDK_A_CODE:   rd_val = {20'h00000, cfg_q.code};
      `RDK_A_STAT:   rd_val = {27'h0000000, ahi_q, alo_q, relay_out, locked};
      `RDK_A_VOUT:   rd_val = {{16{aout_mv[15]}}, aout_mv};
      `RDK_A_CTRL:   rd_val = 32'h00000000;
      default:       rd_val = 32'h00000000;
    endcase
  endfunction

  // apb slave: one wait state, write lands on the edge that samples pready
  assign apb_wr = psel && penable && pwrite && pready;

  always_comb begin
    pready_d  = psel && penable && !pready;
    ok_d      = ok_q;
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    if (pready_d) begin
      ok_d      = pwrite ? wr_ok(paddr, pwdata, 1'b1, cfg_q.aout.bipolar) :
                  1'b0;
      pslverr_d = pwrite ? !wr_ok(paddr, pwdata, 1'b1, cfg_q.aout.bipolar) :
                  (paddr > `RDK_A_CTRL || paddr[1:0] != 2'h0);
      prdata_d  = pwrite ? 32'h00000000 : rd_val(paddr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      ok_q    <= 1'b0;
    end else begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
      ok_q    <= ok_d;
    end
  end

  // configuration store; host writes take precedence over a panel write in the same cycle
  always_comb begin
    cfg_d       = cfg_q;
    restore_apb = 1'b0;
    w_en        = 1'b0;
    w_addr      = 8'h00;
    w_data      = 32'h00000000;
    if (apb_wr && ok_q) begin
      w_en   = 1'b1;
      w_addr = paddr;
      w_data = pwdata;
    end else if (panel_wr.valid && !locked &&
                 wr_ok(panel_wr.addr, panel_wr.data, 1'b0, cfg_q.aout.bipolar)) begin
      w_en   = 1'b1;
      w_addr = panel_wr.addr;
      w_data = panel_wr.data;
    end
    if (w_en) begin
      case (w_addr)
        `RDK_A_RELAY: begin
          for (int i = 0; i < 2; i++) begin
            cfg_d.relay[i] = rdk_relay_s'(w_data[4*i +: 4]);
            if (!w_data[4*i+3]) cfg_d.relay[i].src = cfg_q.relay[i].src;
          end
        end
        `RDK_A_ALARM:  {cfg_d.alarm_inside, cfg_d.alarm_en} = w_data[1:0];
        `RDK_A_ALM_LO: cfg_d.alm_lo = w_data;
        `RDK_A_ALM_HI: cfg_d.alm_hi = w_data;
        `RDK_A_AOUT:   cfg_d.aout = rdk_aout_s'(w_data[7:0]);
        `RDK_A_UD_LO:  cfg_d.ud_lo = w_data;
        `RDK_A_UD_HI:  cfg_d.ud_hi = w_data;
        `RDK_A_MAN:    cfg_d.man = w_data;
        `RDK_A_FS:     cfg_d.fs = w_data;
        `RDK_A_CODE:   cfg_d.code = w_data[11:0];
        `RDK_A_CTRL:   restore_apb = w_data[0];
        default:       cfg_d = cfg_q;
      endcase
    end
    // a restore reloads every setting, lock code included; calibration lives elsewhere
    if (restore_apb || restore_kp) cfg_d = CFG_RST;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) cfg_q <= CFG_RST;
    else cfg_q <= cfg_d;
  end

  // alarms and relays
  always_comb begin
    logic below;
    logic above;
    below = field_rdg < cfg_q.alm_lo;
    above = field_rdg > cfg_q.alm_hi;
    if (cfg_q.alarm_inside) begin
      alo_d = cfg_q.alarm_en && !below && !above;
      ahi_d = cfg_q.alarm_en && !below && !above;
    end else begin
      alo_d = cfg_q.alarm_en && below;
      ahi_d = cfg_q.alarm_en && above;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_relay
    always_comb begin
      if (!cfg_q.relay[g].alarm_mode) begin
        relay_d[g] = cfg_q.relay[g].man_on;
      end else begin
        case (cfg_q.relay[g].src)
          `RDK_SRC_LO: relay_d[g] = alo_q;
          `RDK_SRC_HI: relay_d[g] = ahi_q;
          default:     relay_d[g] = alo_q || ahi_q;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alo_q     <= 1'b0;
      ahi_q     <= 1'b0;
      relay_out <= 2'h0;
    end else begin
      alo_q     <= alo_d;
      ahi_q     <= ahi_d;
      relay_out <= relay_d;
    end
  end

  // dc output; refreshed only on the update tick so the value seen is one sample
  rdk_aout_calc u_calc (
    .cfg    (cfg_q.aout),
    .rdg    (field_rdg),
    .fs     (cfg_q.fs),
    .ud_lo  (cfg_q.ud_lo),
    .ud_hi  (cfg_q.ud_hi),
    .man    (cfg_q.man),
    .ctl_mv (ctl_mv),
    .v_mv   (calc_mv)
  );

  always_comb begin
    tick_d    = (upd_cnt_q == UW'(UPD_CYC - 1));
    upd_cnt_d = tick_d ? '0 : upd_cnt_q + UW'(1);
    aout_d    = tick_q ? calc_mv : aout_mv;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      upd_cnt_q <= '0;
      tick_q    <= 1'b0;
      aout_mv   <= 16'sh0000;
    end else begin
      upd_cnt_q <= upd_cnt_d;
      tick_q    <= tick_d;
      aout_mv   <= aout_d;
    end
  end

  // keypad: long presses open the code prompt or the revision/restore sequence
  rdk_hold_timer #(.HOLD_CYC(HOLD_CYC)) u_enter_hold (
    .ref_clk (ref_clk),
    .srst    (srst),
    .key     (key_enter),
    .fire    (enter_fire)
  );

  rdk_hold_timer #(.HOLD_CYC(HOLD_CYC)) u_esc_hold (
    .ref_clk (ref_clk),
    .srst    (srst),
    .key     (key_escape),
    .fire    (esc_fire)
  );

  assign enter_rise = key_enter && !enter_q;
  assign esc_rise   = key_escape && !esc_q;

  always_comb begin
    kp_d       = kp_q;
    lock_d     = locked;
    code_in_d  = code_in_q;
    dcnt_d     = dcnt_q;
    restore_kp = 1'b0;
    ind_d      = panel_wr.valid && locked;
    case (kp_q)
      KP_IDLE: begin
        dcnt_d = 2'h0;
        if (enter_fire) kp_d = KP_CODE;
        else if (esc_fire) kp_d = KP_REV;
      end
      KP_CODE: begin
        if (esc_rise) begin
          kp_d = KP_IDLE;
        end else if (digit_vld) begin
          code_in_d = {code_in_q[3:0], digit};
          dcnt_d    = dcnt_q + 2'h1;
          if (dcnt_q == 2'h2) begin
            if ({code_in_q, digit} == cfg_q.code) lock_d = !locked;
            kp_d = KP_IDLE;
          end
        end
      end
      KP_REV: begin
        if (enter_rise) kp_d = KP_OFFER;
        else if (esc_rise) kp_d = KP_IDLE;
      end
      KP_OFFER: begin
        if (panel_yes) begin
          restore_kp = !locked;
          ind_d      = locked;
          kp_d       = KP_IDLE;
        end else if (esc_rise || enter_rise) begin
          kp_d = KP_IDLE;
        end
      end
      default: kp_d = KP_IDLE;
    endcase
    if (restore_apb || restore_kp) lock_d = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      kp_q           <= KP_IDLE;
      locked         <= 1'b0;
      code_in_q      <= 8'h00;
      dcnt_q         <= 2'h0;
      enter_q        <= 1'b0;
      esc_q          <= 1'b0;
      locked_ind     <= 1'b0;
      code_prompt    <= 1'b0;
      fw_rev_show    <= 1'b0;
      restore_prompt <= 1'b0;
    end else begin
      kp_q           <= kp_d;
      locked         <= lock_d;
      code_in_q      <= code_in_d;
      dcnt_q         <= dcnt_d;
      enter_q        <= key_enter;
      esc_q          <= key_escape;
      locked_ind     <= ind_d;
      code_prompt    <= (kp_d == KP_CODE);
      fw_rev_show    <= (kp_d == KP_REV);
      restore_prompt <= (kp_d == KP_OFFER);
    end
  end

  // checks
  assign lim_mv = $signed({12'h000, cfg_q.aout.limit}) * `RDK_MV_PER_V;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_relay_manual;
    !cfg_q.relay[0].alarm_mode ##1 !cfg_q.relay[0].alarm_mode |-> relay_out[0] == $past(cfg_q.relay[0].man_on);
  endproperty
  a_relay_manual: assert property (p_relay_manual) else $error("relay 0 ignores manual bit");

  property p_relay_alarm;
    cfg_q.relay[1].alarm_mode && cfg_q.relay[1].src == `RDK_SRC_BOTH && (alo_q || ahi_q)
      |=> relay_out[1];
  endproperty
  a_relay_alarm: assert property (p_relay_alarm) else $error("relay 1 misses alarm");

  property p_outside;
    cfg_q.alarm_en && !cfg_q.alarm_inside && field_rdg > cfg_q.alm_hi |=> ahi_q;
  endproperty
  a_outside: assert property (p_outside) else $error("high alarm not raised");

  property p_update_rate;
    !tick_q |=> $stable(aout_mv);
  endproperty
  a_update_rate: assert property (p_update_rate) else $error("output moved off tick");

  property p_off;
    tick_q && cfg_q.aout.mode == `RDK_M_OFF |=> aout_mv == 16'sh0000;
  endproperty
  a_off: assert property (p_off) else $error("off mode not zero");

  property p_limit;
    tick_q |=> (aout_mv <= $past(lim_mv)) && (aout_mv >= -$past(lim_mv));
  endproperty
  a_limit: assert property (p_limit) else $error("output beyond limit");

  property p_unipolar;
    tick_q && !cfg_q.aout.bipolar |=> aout_mv >= 16'sh0000;
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar output negative");

  property p_lock_hold;
    locked && panel_wr.valid && !apb_wr && !restore_kp |=> cfg_q == $past(cfg_q) ##0 locked_ind;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked panel write changed setting");

  property p_code_restore;
    restore_apb || restore_kp |=> cfg_q.code == `RDK_RST_CODE && !locked;
  endproperty
  a_code_restore: assert property (p_code_restore) else $error("lock code not restored");

  property p_refuse;
    locked && !restore_apb && kp_q == KP_OFFER && panel_yes
      |=> locked_ind && locked && kp_q == KP_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked restore accepted");

  c_lock: cover property ($rose(locked));
  c_restore: cover property (restore_kp);
  c_relay_alarm: cover property (cfg_q.relay[0].alarm_mode && relay_out[0]);
endmodule // rdk_ctrl

// [dv/rdk_panel_model.sv]
`timescale 1ns/1ps
module rdk_panel_model (
  input  wire logic              ref_clk,
  output logic                   key_enter,
  output logic                   key_escape,
  output logic                   digit_vld,
  output logic [3:0]             digit,
  output logic                   panel_yes,
  output rdk_pkg::rdk_panel_wr_s panel_wr
);
  import rdk_pkg::*;
  initial begin
    key_enter = 1'b0;
    key_escape = 1'b0;
    digit_vld = 1'b0;
    digit = 4'hF;
    panel_yes = 1'b0;
    panel_wr = '0;
  end
  task automatic hold(input logic esc, input int n);
    @(posedge ref_clk);
    if (esc) key_escape <= 1'b1;
    else key_enter <= 1'b1;
    repeat (n) @(posedge ref_clk);
    key_enter <= 1'b0;
    key_escape <= 1'b0;
  endtask
  // three digits, most significant first
  task automatic code(input logic [11:0] c);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      digit_vld <= 1'b1;
      digit <= c[11-4*i -: 4];
      @(posedge ref_clk);
      digit_vld <= 1'b0;
      digit <= ~c[11-4*i -: 4]; // idle digit bus carries no stale value
    end
  endtask
  task automatic yes();
    @(posedge ref_clk);
    panel_yes <= 1'b1;
    @(posedge ref_clk);
    panel_yes <= 1'b0;
  endtask
  task automatic pwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    panel_wr <= '{1'b1, a, d};
    @(posedge ref_clk);
    panel_wr <= '{1'b0, ~a, ~d};
  endtask
endmodule // rdk_panel_model

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "rdk_consts.svh"
module testbench;
  import rdk_pkg::*;
  localparam int UPD = 20;
  localparam int HOLD = 8;
  logic                ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  logic signed [31:0]  field_rdg;
  logic signed [15:0]  ctl_mv, aout_mv;
  logic [1:0]          relay_out;
  logic                ke, kx, dv, py, locked, locked_ind, code_prompt, fw_rev_show, rst_pr;
  logic [3:0]          dg;
  rdk_panel_wr_s       pw;
  logic [33:0]         expq[$];
  logic [33:0]         e;
  int                  miscompares = 0;
  int                  checked = 0;
  rdk_ctrl #(.UPD_CYC(UPD), .HOLD_CYC(HOLD)) rdk_ctrl_i (.ref_clk(ref_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .field_rdg(field_rdg),
    .ctl_mv(ctl_mv), .key_enter(ke), .key_escape(kx), .digit_vld(dv), .digit(dg),
    .panel_yes(py), .panel_wr(pw), .relay_out(relay_out), .aout_mv(aout_mv),
    .locked(locked), .locked_ind(locked_ind), .code_prompt(code_prompt),
    .fw_rev_show(fw_rev_show), .restore_prompt(rst_pr));
  rdk_panel_model rdk_panel_model_i (.ref_clk(ref_clk), .key_enter(ke), .key_escape(kx),
    .digit_vld(dv), .digit(dg), .panel_yes(py), .panel_wr(pw));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] x);
    @(posedge ref_clk);
    expq.push_back({~w, err, x});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic err, input logic [31:0] x);
    apb(1'b0, a, 32'h0, err, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, err, 32'h0);
  endtask
  // write data is not returned, so only the error flag is judged there
  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      e = expq.pop_front();
      chk({e[33] ? prdata : e[31:0], pslverr}, {e[31:0], e[32]});
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] vexp(input int v, input int lim, input logic bip);
    if (v > lim * 1000) v = lim * 1000;
    if (v < -lim * 1000) v = -lim * 1000;
    if (!bip && v < 0) v = 0;
    return v;
  endfunction
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [7:0]  md[8] = '{8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'h2B, 8'hA3, 8'hAC, 8'h1C};
    int          raw[8] = '{0, 1750, 5000, -5000, -5000, -5000, 0, 0};
    logic [15:0] s;
    int          c;
    s = 16'h001D;
    repeat (7) s = lfsr(s);
    c = int'(s[13:0]) - 8000;
    srst <= 1'b1;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    field_rdg <= 40000;
    ctl_mv <= 16'(c);
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`RDK_A_AOUT, 1'b0, 32'hA8);
    rd(`RDK_A_CODE, 1'b0, 32'h123);
    rd(8'h34, 1'b1, 32'h0);
    wr(`RDK_A_VOUT, 32'h1, 1'b1);
    wr(`RDK_A_ALARM, 32'h1, 1'b0);
    wr(`RDK_A_RELAY, 32'h89, 1'b0);
    repeat (4) @(posedge ref_clk);
    rd(`RDK_A_STAT, 1'b0, 32'h12);
    wr(`RDK_A_RELAY, 32'hA9, 1'b0);
    repeat (4) @(posedge ref_clk);
    rd(`RDK_A_STAT, 1'b0, 32'h16);
    field_rdg <= 17500;
    wr(`RDK_A_ALARM, 32'h3, 1'b0);
    repeat (4) @(posedge ref_clk);
    rd(`RDK_A_STAT, 1'b0, 32'h1E);
    wr(`RDK_A_RELAY, 32'h40, 1'b0);
    repeat (4) @(posedge ref_clk);
    rd(`RDK_A_STAT, 1'b0, 32'h1C);
    wr(`RDK_A_MAN, -32'sd50000, 1'b0);
    wr(`RDK_A_MAN, 32'd100001, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(`RDK_A_AOUT, {24'h0, md[i]}, 1'b0);
      repeat (2 * UPD + 4) @(posedge ref_clk);
      rd(`RDK_A_VOUT, 1'b0, vexp(md[i][2:0] == 3'h4 ? c : raw[i], md[i][7:4], md[i][3]));
    end
    rdk_panel_model_i.hold(1'b0, HOLD + 4);
    chk(code_prompt, 1'b1);
    rdk_panel_model_i.code(12'h123);
    repeat (3) @(posedge ref_clk);
    chk(locked, 1'b1);
    rdk_panel_model_i.pwr(`RDK_A_AOUT, 32'hA9);
    @(posedge ref_clk);
    chk(locked_ind, 1'b1);
    rd(`RDK_A_AOUT, 1'b0, 32'h1C);
    rdk_panel_model_i.hold(1'b1, HOLD + 4);
    chk(fw_rev_show, 1'b1);
    rdk_panel_model_i.hold(1'b0, 1);
    repeat (3) @(posedge ref_clk);
    chk(rst_pr, 1'b1);
    rdk_panel_model_i.yes();
    @(posedge ref_clk);
    chk(locked_ind, 1'b1);
    chk(locked, 1'b1);
    wr(`RDK_A_CODE, 32'h456, 1'b0);
    rd(`RDK_A_CODE, 1'b0, 32'h456);
    wr(`RDK_A_CTRL, 32'h1, 1'b0);
    rd(`RDK_A_CODE, 1'b0, 32'h123);
    chk(locked, 1'b0);
    rdk_panel_model_i.pwr(`RDK_A_AOUT, 32'hA9);
    rdk_panel_model_i.pwr(`RDK_A_CODE, 32'h456);
    rd(`RDK_A_AOUT, 1'b0, 32'hA9);
    rd(`RDK_A_CODE, 1'b0, 32'h123);
    wr(`RDK_A_CODE, 32'h789, 1'b0);
    rdk_panel_model_i.hold(1'b1, HOLD + 4);
    rdk_panel_model_i.hold(1'b0, 1);
    rdk_panel_model_i.yes();
    rd(`RDK_A_AOUT, 1'b0, 32'hA8);
    rd(`RDK_A_CODE, 1'b0, 32'h123);
    end_of_test();
  end
endmodule // testbench
